// ---- src/gpp_pkg.sv ----
// Constants shared by the port 1 / port 3 / port 4 GPIO block
// Operation
// - Port 3 pins: own direction and level.
// - SPI-assigned port 3 pins ignore direction/level.
// - Select output 0 flash, 1 connector.
// - Select as input: undriven, factory default.
// - Serial function overrides all port 4 settings.
// - Port 4 inputs read inverted RS232 level.
// - Port 4 outputs drive inverted RS232 level.
// - Redirection detect input readable by firmware.
// - Port 1 pins: own direction and level.
package gpp_pkg;
   // ***************
   // Widths and masks
   // ***************
   localparam int GPP_P1_WIDTH = 8;
   localparam int GPP_P3_WIDTH = 6;
   localparam int GPP_P4_WIDTH = 8;
   localparam int GPP_SPI_PINS = 4;
   localparam int GPP_SYNC_STAGES = 3;
   // Port 4 bits that face RS232 receivers / drivers
   localparam logic [7:0] GPP_P4_IN_MASK = 8'hd9;
   localparam logic [7:0] GPP_P4_OUT_MASK = 8'h26;
   // ***************
   // Reset values
   // ***************
   localparam logic [7:0] GPP_DIR_RESET = 8'h00;
   localparam logic [7:0] GPP_LVL_RESET = 8'h00;
   localparam logic GPP_SPI_SEL_FLASH = 1'b0;
   localparam logic GPP_SPI_SEL_CONN = 1'b1;
   localparam logic GPP_SPI_SEL_FACTORY = GPP_SPI_SEL_FLASH;
endpackage

// ---- src/gpp_sync.sv ----
// Three-stage input synchroniser for a bus of pins
`timescale 1ns/100ps
module gpp_sync
   import gpp_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] pinSync
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] held;
   } gpp_sync_state_type;

   gpp_sync_state_type state_r;
   gpp_sync_state_type state_nxt;

   always_comb begin
      state_nxt = state_r;
      state_nxt.s1 = pinIn;
      state_nxt.s2 = state_r.s1;
      state_nxt.s3 = state_r.s2;
      // Only accept a level once two late stages agree
      for (int i = 0; i < WIDTH; i++) begin
         if (state_r.s2[i] == state_r.s3[i]) begin
            state_nxt.held[i] = state_r.s3[i];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign pinSync = state_r.held;
endmodule // gpp_sync

// ---- src/gpp_ports.sv ----
// Port 1, 3 and 4 GPIO logic with SPI and serial alternate functions
`timescale 1ns/100ps
module gpp_ports
   import gpp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   // Port 1
   input wire logic [GPP_P1_WIDTH-1:0] p1DirOut,
   input wire logic [GPP_P1_WIDTH-1:0] p1OutLevel,
   input wire logic [GPP_P1_WIDTH-1:0] p1PinIn,
   output logic [GPP_P1_WIDTH-1:0] p1PinOut,
   output logic [GPP_P1_WIDTH-1:0] p1PinOe,
   output logic [GPP_P1_WIDTH-1:0] p1ReadData,
   // Port 3
   input wire logic [GPP_P3_WIDTH-1:0] p3DirOut,
   input wire logic [GPP_P3_WIDTH-1:0] p3OutLevel,
   input wire logic p3SpiAssign,
   input wire logic [GPP_SPI_PINS-1:0] spiPinOut,
   input wire logic [GPP_SPI_PINS-1:0] spiPinOe,
   input wire logic [GPP_P3_WIDTH-1:0] p3PinIn,
   output logic [GPP_P3_WIDTH-1:0] p3PinOut,
   output logic [GPP_P3_WIDTH-1:0] p3PinOe,
   output logic [GPP_P3_WIDTH-1:0] p3ReadData,
   output logic [GPP_SPI_PINS-1:0] spiPinIn,
   // SPI target select
   input wire logic spiSelDirOut,
   input wire logic spiSelLevel,
   output logic spiTargetSelect,
   output logic spiTargetSelectOe,
   // Console redirection detect
   input wire logic crDetectPin,
   output logic crDetect,
   // Port 4 / first serial port
   input wire logic [GPP_P4_WIDTH-1:0] p4DirOut,
   input wire logic [GPP_P4_WIDTH-1:0] p4OutLevel,
   input wire logic p4SerialAssign,
   input wire logic [GPP_P4_WIDTH-1:0] serialLineOut,
   input wire logic [GPP_P4_WIDTH-1:0] p4PinIn,
   output logic [GPP_P4_WIDTH-1:0] p4PinOut,
   output logic [GPP_P4_WIDTH-1:0] p4PinOe,
   output logic [GPP_P4_WIDTH-1:0] p4ReadData,
   output logic [GPP_P4_WIDTH-1:0] serialLineIn
);
   localparam int IN_W = GPP_P1_WIDTH + GPP_P3_WIDTH + GPP_P4_WIDTH + 1;

   // ***************
   // Registered state
   // ***************
   typedef struct packed {
      logic [GPP_P1_WIDTH-1:0] p1Out;
      logic [GPP_P1_WIDTH-1:0] p1Oe;
      logic [GPP_P3_WIDTH-1:0] p3Out;
      logic [GPP_P3_WIDTH-1:0] p3Oe;
      logic spiSel;
      logic spiSelOe;
      logic [GPP_P4_WIDTH-1:0] p4Out;
      logic [GPP_P4_WIDTH-1:0] p4Oe;
   } gpp_state_type;

   gpp_state_type state_r;
   gpp_state_type state_nxt;
   logic [IN_W-1:0] syncIn;
   logic [GPP_P1_WIDTH-1:0] p1Sync;
   logic [GPP_P3_WIDTH-1:0] p3Sync;
   logic [GPP_P4_WIDTH-1:0] p4Sync;
   logic crSync;

   // ***************
   // Input synchronisers
   // ***************
   gpp_sync #(
      .WIDTH(IN_W)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pinIn({crDetectPin, p4PinIn, p3PinIn, p1PinIn}),
      .pinSync(syncIn)
   );

   assign p1Sync = syncIn[GPP_P1_WIDTH-1:0];
   assign p3Sync = syncIn[GPP_P1_WIDTH+GPP_P3_WIDTH-1:GPP_P1_WIDTH];
   assign p4Sync = syncIn[IN_W-2:GPP_P1_WIDTH+GPP_P3_WIDTH];
   assign crSync = syncIn[IN_W-1];

   // ***************
   // Next-state logic
   // ***************
   always_comb begin
      state_nxt = state_r;
      state_nxt.p1Out = p1OutLevel;
      state_nxt.p1Oe = p1DirOut;
      for (int i = 0; i < GPP_P3_WIDTH; i++) begin
         if (p3SpiAssign && i < GPP_SPI_PINS) begin
            state_nxt.p3Out[i] = spiPinOut[i];
            state_nxt.p3Oe[i] = spiPinOe[i];
         end else begin
            state_nxt.p3Out[i] = p3OutLevel[i];
            state_nxt.p3Oe[i] = p3DirOut[i];
         end
      end
      // Undriven select lets the board pull it to the factory route
      state_nxt.spiSelOe = spiSelDirOut;
      state_nxt.spiSel = spiSelDirOut ? spiSelLevel : GPP_SPI_SEL_FACTORY;
      if (p4SerialAssign) begin
         // Serial port owns the line drivers outright
         state_nxt.p4Out = serialLineOut & GPP_P4_OUT_MASK;
         state_nxt.p4Oe = GPP_P4_OUT_MASK;
      end else begin
         // Inverting driver: level 0 gives RS232 high
         state_nxt.p4Out = ~p4OutLevel;
         // Receiver-facing bits are never driven even if software asks
         state_nxt.p4Oe = p4DirOut & ~GPP_P4_IN_MASK;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r.p1Out <= GPP_LVL_RESET;
         state_r.p1Oe <= GPP_DIR_RESET;
         state_r.p3Out <= GPP_LVL_RESET[GPP_P3_WIDTH-1:0];
         state_r.p3Oe <= GPP_DIR_RESET[GPP_P3_WIDTH-1:0];
         state_r.spiSel <= GPP_SPI_SEL_FACTORY;
         state_r.spiSelOe <= 1'b0;
         state_r.p4Out <= GPP_LVL_RESET;
         state_r.p4Oe <= GPP_DIR_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ***************
   // Outputs
   // ***************
   assign p1PinOut = state_r.p1Out;
   assign p1PinOe = state_r.p1Oe;
   assign p1ReadData = p1Sync;
   assign p3PinOut = state_r.p3Out;
   assign p3PinOe = state_r.p3Oe;
   assign p3ReadData = p3Sync;
   assign spiPinIn = p3Sync[GPP_SPI_PINS-1:0];
   assign spiTargetSelect = state_r.spiSel;
   assign spiTargetSelectOe = state_r.spiSelOe;
   assign crDetect = crSync;
   assign p4PinOut = state_r.p4Out;
   assign p4PinOe = state_r.p4Oe;
   // Pins are raw RS232 sense; read value is inverted
   assign p4ReadData = ~p4Sync & GPP_P4_IN_MASK;
   assign serialLineIn = p4Sync & GPP_P4_IN_MASK;
endmodule // gpp_ports

// ---- testbench/gpp_chk.sv ----
// Concurrent checks on the port 1/3/4 GPIO block
`timescale 1ns/100ps
module gpp_chk
   import gpp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] p1DirOut,
   input wire logic [7:0] p1PinOe,
   input wire logic [5:0] p3DirOut,
   input wire logic p3SpiAssign,
   input wire logic [3:0] spiPinOe,
   input wire logic [5:0] p3PinOe,
   input wire logic spiSelDirOut,
   input wire logic spiSelLevel,
   input wire logic spiTargetSelect,
   input wire logic spiTargetSelectOe,
   input wire logic [7:0] p4OutLevel,
   input wire logic p4SerialAssign,
   input wire logic [7:0] p4PinIn,
   input wire logic [7:0] p4PinOut,
   input wire logic [7:0] p4PinOe,
   input wire logic [7:0] p4ReadData
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_p1; $past(rst_n) |-> p1PinOe == $past(p1DirOut); endproperty
   a_p1: assert property (p_p1) else $error("p1 enable");
   property p_p3; $past(rst_n) && !$past(p3SpiAssign) |-> p3PinOe == $past(p3DirOut); endproperty
   a_p3: assert property (p_p3) else $error("p3 enable");
   property p_spi; $past(rst_n) && $past(p3SpiAssign) |-> p3PinOe[3:0] == $past(spiPinOe);
   endproperty
   a_spi: assert property (p_spi) else $error("spi enable");
   property p_sel; $past(rst_n) && $past(spiSelDirOut) |->
      spiTargetSelectOe && spiTargetSelect == $past(spiSelLevel); endproperty
   a_sel: assert property (p_sel) else $error("select drive");
   property p_def; !spiTargetSelectOe |-> spiTargetSelect == GPP_SPI_SEL_FACTORY; endproperty
   a_def: assert property (p_def) else $error("select default");
   property p_ser; $past(rst_n) && $past(p4SerialAssign) |-> p4PinOe == GPP_P4_OUT_MASK;
   endproperty
   a_ser: assert property (p_ser) else $error("serial enable");
   property p_out; $past(rst_n) && !$past(p4SerialAssign) |->
      (p4PinOut & p4PinOe) == (~$past(p4OutLevel) & p4PinOe); endproperty
   a_out: assert property (p_out) else $error("p4 drive");
   // Five stable samples cover the three flops plus the hold stage
   property p_rd; $stable(p4PinIn)[*5] |-> p4ReadData == (~p4PinIn & GPP_P4_IN_MASK); endproperty
   a_rd: assert property (p_rd) else $error("p4 read");
   c_spi: cover property (p3SpiAssign);
   c_ser: cover property (p4SerialAssign);
   c_sel: cover property (spiTargetSelectOe && spiTargetSelect);
endmodule // gpp_chk
bind gpp_ports gpp_chk gpp_chk_inst (.*);

// ---- testbench/gpp_far_model.sv ----
// RS232 transceiver pins seen from the port 4 side
`timescale 1ns/100ps
module gpp_far_model (
   input wire logic [7:0] lineLevel,
   input wire logic [7:0] p4PinOut,
   input wire logic [7:0] p4PinOe,
   output logic [7:0] p4PinIn
);
   // Driven bits read back their own drive, the rest follow the line
   assign p4PinIn = (p4PinOe & p4PinOut) | (~p4PinOe & lineLevel);
endmodule // gpp_far_model

// ---- testbench/tb.sv ----
// Self-checking bench for the port 1/3/4 GPIO block
`timescale 1ns/100ps
module tb;
   import gpp_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic p3SpiAssign, spiSelDirOut, spiSelLevel, spiTargetSelect, spiTargetSelectOe;
   logic crDetectPin, crDetect, p4SerialAssign;
   logic [7:0] p1DirOut, p1OutLevel, p1PinIn, p1PinOut, p1PinOe, p1ReadData, lineLevel;
   logic [5:0] p3DirOut, p3OutLevel, p3PinIn, p3PinOut, p3PinOe, p3ReadData;
   logic [3:0] spiPinOut, spiPinOe, spiPinIn;
   logic [7:0] p4DirOut, p4OutLevel, serialLineOut, p4PinIn, p4PinOut, p4PinOe;
   logic [7:0] p4ReadData, serialLineIn;
   int error_cnt = 0;
   int samples_checked = 0;
   gpp_ports gpp_ports_inst (.*);
   gpp_far_model gpp_far_model_inst (.lineLevel(lineLevel), .p4PinOut(p4PinOut),
      .p4PinOe(p4PinOe), .p4PinIn(p4PinIn));
   always #25 sys_clk = ~sys_clk;
   task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
      samples_checked++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
         error_cnt++;
      end
   endtask
   task step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task end_sim;
      $display("checked %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      {p1DirOut, p1OutLevel, p1PinIn, p3DirOut, p3OutLevel, p3PinIn, p3SpiAssign} = '0;
      {spiPinOut, spiPinOe, spiSelDirOut, spiSelLevel, crDetectPin, lineLevel} = '0;
      {p4DirOut, p4OutLevel, p4SerialAssign, serialLineOut} = '0;
      step(6);
      chk(p1PinOe, 8'h0, "reset p1 enables");
      chk(p4PinOe, 8'h0, "reset p4 enables");
      chk({spiTargetSelectOe, p3PinOe}, 7'h0, "reset p3");
      rst_n <= 1'b1;
      @(posedge sys_clk);
      p1DirOut <= 8'h5a;
      p1OutLevel <= 8'h0f;
      p1PinIn <= 8'ha5;
      step(4);
      chk(p1PinOe, 8'h5a, "p1 enable");
      chk(p1PinOut & p1PinOe, 8'h0a, "p1 drive");
      chk(p1ReadData, 8'ha5, "p1 read");
      @(posedge sys_clk);
      {p3DirOut, p3OutLevel, spiPinOe, spiPinOut, p3SpiAssign} <= {6'h3f, 6'h2a, 4'h3, 4'h1, 1'b1};
      p3PinIn <= 6'h15;
      step(1);
      chk(p3PinOe, 6'h33, "p3 spi enable");
      chk(p3PinOut & p3PinOe, 6'h21, "p3 spi drive");
      @(posedge sys_clk);
      p3SpiAssign <= 1'b0;
      step(1);
      chk(p3PinOut & p3PinOe, 6'h2a, "p3 gpio drive");
      for (int i = 0; i < 2; i++) begin
         @(posedge sys_clk);
         {spiSelDirOut, spiSelLevel} <= {1'b1, i[0]};
         step(1);
         chk({spiTargetSelectOe, spiTargetSelect}, {7'h1, i[0]}, "select");
      end
      @(posedge sys_clk);
      {spiSelDirOut, crDetectPin} <= 2'h1;
      step(4);
      chk({spiTargetSelectOe, spiTargetSelect}, 8'h0, "select default");
      chk(crDetect, 8'h1, "redirect detect");
      chk(p3ReadData, 8'h15, "p3 read");
      chk(spiPinIn, 8'h5, "spi sense");
      @(posedge sys_clk);
      {p4DirOut, p4OutLevel, lineLevel} <= {8'h26, 8'h24, 8'h48};
      step(4);
      chk(p4PinOut & p4PinOe, 8'h02, "p4 drive");
      chk(p4ReadData, 8'h91, "p4 read");
      @(posedge sys_clk);
      {p4SerialAssign, serialLineOut} <= {1'b1, 8'hff};
      step(4);
      chk(p4PinOut & p4PinOe, 8'h26, "serial drive");
      chk(serialLineIn, 8'h48, "serial sense");
      end_sim;
   end
endmodule // tb
